// [hdl/ocp_top.sv]
// output contact pulse latch top: avalon slave, time base, four channels
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module ocp_top
   import ocp_pkg::*;
#(
   // clock cycles per 0.1 s tick; a bench may shorten it to reach the timed paths
   parameter int TICK_CYCLES = OCP_TICK_CYCLES
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // fault requests: trip, first, second, third spare
   input wire logic [OCP_NUM_OUT-1:0] fault_req,
   input wire logic ext_unit_reset,
   // contact coils
   output logic [OCP_NUM_OUT-1:0] coil_drive
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [OCP_MODE_W-1:0] mode_reg;
   logic [OCP_TIME_W-1:0] time_reg [OCP_NUM_OUT];
   logic ack_reg;
   logic unit_reset_reg;
   logic [23:0] div_reg;
   logic tick_reg;
   wire logic [OCP_NUM_OUT-1:0] coil_w;
   wire logic [OCP_NUM_OUT-1:0] busy_w;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   // one wait state: ack rises the cycle after the request
   wire logic req = (avs_read || avs_write) && !ack_reg;
   wire logic wr_en = avs_write && ack_reg;
   wire logic wr_mode = wr_en && (avs_address == OCP_ADDR_MODE);
   wire logic wr_reset = wr_en && (avs_address == OCP_ADDR_RESET) && avs_writedata[OCP_BIT_UNIT_RESET];
   wire logic [OCP_TIME_W-1:0] wdat_time = avs_writedata[OCP_TIME_W-1:0];
   // time writes whose low 5 bits are out of range are ignored, setting keeps its value
   wire logic time_ok = (wdat_time >= OCP_TIME_MIN) && (wdat_time <= OCP_TIME_MAX);
   wire logic [3:0] time_idx = avs_address - OCP_ADDR_TRIP_TIME;
   wire logic time_sel = (avs_address >= OCP_ADDR_TRIP_TIME) && (avs_address <= OCP_ADDR_SPARE3_TIME);
   logic [31:0] rd_mux;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (avs_address == OCP_ADDR_MODE)
         rd_mux = {25'h0, mode_reg};
      else if (time_sel)
         rd_mux = {27'h0, time_reg[time_idx[1:0]]};
      else if (avs_address == OCP_ADDR_STATUS)
         rd_mux = {24'h0, busy_w, coil_drive};
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         ack_reg <= 1'b0;
      else
         ack_reg <= req;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         avs_readdata <= 32'h0000_0000;
      else if (req)
         avs_readdata <= rd_mux;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !req;
   end

   // mode register: bits 3:0 one per output, 1 = pulsed; bits 6:4 force spares 1 to 3 latched
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         mode_reg <= {3'h0, OCP_MODE_RESET};
      else if (wr_mode)
         mode_reg <= avs_writedata[OCP_MODE_W-1:0];
   end

   // time settings, one register per output
   genvar g;
   generate
      for (g = 0; g < OCP_NUM_OUT; g++)
      begin : g_time
         always_ff @(posedge core_clk or posedge rst)
         begin
            if (rst)
               time_reg[g] <= OCP_TIME_DEFAULT;
            else if (wr_en && time_sel && time_idx == 4'(g) && time_ok)
               time_reg[g] <= wdat_time;
         end
      end
   endgenerate

   // unit reset pulse from software or the reset input
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         unit_reset_reg <= 1'b0;
      else
         unit_reset_reg <= wr_reset || ext_unit_reset;
   end

   // ---------------------------------------------------------------
   // 0.1 s time base
   // ---------------------------------------------------------------
   localparam logic [23:0] DIV_LAST = 24'(TICK_CYCLES - 1);
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         div_reg <= 24'h00_0000;
         tick_reg <= 1'b0;
      end
      else
      begin
         tick_reg <= (div_reg == DIV_LAST);
         div_reg <= (div_reg == DIV_LAST) ? 24'h00_0000 : div_reg + 24'h00_0001;
      end
   end

   // ---------------------------------------------------------------
   // channel modes
   // ---------------------------------------------------------------
   // blocked or out of service spares are held latched so their time is unused
   wire logic [OCP_NUM_OUT-1:0] pulsed_w;
   assign pulsed_w[0] = mode_reg[0];
   assign pulsed_w[1] = mode_reg[1] && !mode_reg[OCP_BIT_SPARE1_BLOCK];
   assign pulsed_w[2] = mode_reg[2] && !mode_reg[OCP_BIT_SPARE2_LOCKOUT];
   assign pulsed_w[3] = mode_reg[3] && !mode_reg[OCP_BIT_SPARE3_OOS];

   generate
      for (g = 0; g < OCP_NUM_OUT; g++)
      begin : g_chan
         ocp_channel #(
            .REPEAT_EN(g == 0)
         ) u_chan (
            .core_clk(core_clk),
            .rst(rst),
            .tick(tick_reg),
            .pulsed(pulsed_w[g]),
            .pulse_ticks(time_reg[g]),
            .fault(fault_req[g]),
            .unit_reset(unit_reset_reg),
            .coil(coil_w[g]),
            .busy(busy_w[g])
         );
      end
   endgenerate

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         coil_drive <= {OCP_NUM_OUT{1'b0}};
      else
         coil_drive <= coil_w;
   end

   // waitrequest drops exactly one cycle after a request begins
   AST_BUS_ANSWER: assert property (@(posedge core_clk) disable iff (rst)
      ($rose(avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus answer late");
   AST_TIME_RANGE: assert property (@(posedge core_clk) disable iff (rst)
      time_reg[0] >= OCP_TIME_MIN && time_reg[0] <= OCP_TIME_MAX)
      else $error("trip time out of range");
   AST_TICK_ONE: assert property (@(posedge core_clk) disable iff (rst)
      tick_reg |=> !tick_reg)
      else $error("tick longer than one cycle");
endmodule : ocp_top

// [hdl/ocp_pkg.sv]
// package for the output contact pulse latch block
package ocp_pkg;
   // ---------------------------------------------------------------
   // register map (consecutive word addresses, one per register)
   // ---------------------------------------------------------------
   localparam logic [3:0] OCP_ADDR_MODE = 4'h0;
   localparam logic [3:0] OCP_ADDR_TRIP_TIME = 4'h1;
   localparam logic [3:0] OCP_ADDR_SPARE1_TIME = 4'h2;
   localparam logic [3:0] OCP_ADDR_SPARE2_TIME = 4'h3;
   localparam logic [3:0] OCP_ADDR_SPARE3_TIME = 4'h4;
   localparam logic [3:0] OCP_ADDR_STATUS = 4'h5;
   localparam logic [3:0] OCP_ADDR_RESET = 4'h6;
   // ---------------------------------------------------------------
   // fields
   // ---------------------------------------------------------------
   localparam int OCP_NUM_OUT = 4;
   localparam int OCP_TIME_W = 5;
   localparam logic [3:0] OCP_MODE_RESET = 4'h0;
   localparam int OCP_BIT_SPARE1_BLOCK = 4;
   localparam int OCP_BIT_SPARE2_LOCKOUT = 5;
   localparam int OCP_BIT_SPARE3_OOS = 6;
   localparam int OCP_MODE_W = 7;
   localparam int OCP_BIT_UNIT_RESET = 0;
   // ---------------------------------------------------------------
   // time settings in tenths of a second
   // ---------------------------------------------------------------
   localparam logic [4:0] OCP_TIME_MIN = 5'h01;
   localparam logic [4:0] OCP_TIME_MAX = 5'h14;
   localparam logic [4:0] OCP_TIME_DEFAULT = 5'h02;
   localparam int OCP_REPEAT_S = 3;
   localparam int OCP_TICK_PER_S = 10;
   localparam logic [5:0] OCP_REPEAT_TICKS = 6'(OCP_REPEAT_S * OCP_TICK_PER_S);
   localparam int OCP_CLK_HZ = 100_000_000;
   localparam int OCP_TICK_MS = 100;
   localparam int OCP_TICK_CYCLES = OCP_CLK_HZ / 1000 * OCP_TICK_MS;
   // ---------------------------------------------------------------
   // per-output state
   // ---------------------------------------------------------------
   typedef enum logic [3:0]
   {
      OCP_IDLE = 4'b0001,
      OCP_PULSE = 4'b0010,
      OCP_WAIT = 4'b0100,
      OCP_HOLD = 4'b1000
   } ocp_state_type;
endpackage : ocp_pkg

// [hdl/ocp_channel.sv]
// one output contact channel: pulsed or latched drive
`timescale 1ns/100ps
module ocp_channel
   import ocp_pkg::*;
#(
   parameter bit REPEAT_EN = 1'b0
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // time base and settings
   input wire logic tick,
   input wire logic pulsed,
   input wire logic [OCP_TIME_W-1:0] pulse_ticks,
   // request and unit reset
   input wire logic fault,
   input wire logic unit_reset,
   // coil drive
   output logic coil,
   output logic busy
);
   // ---------------------------------------------------------------
   // state and counter
   // ---------------------------------------------------------------
   ocp_state_type state_reg, state_next;
   logic [5:0] cnt_reg, cnt_next;
   wire logic [5:0] cnt_inc = cnt_reg + 6'h01;
   wire logic pulse_done = tick && (cnt_inc >= {1'b0, pulse_ticks});
   wire logic repeat_done = tick && (cnt_inc >= OCP_REPEAT_TICKS);

   // next state for pulsed and latched behaviour
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         OCP_IDLE:
         begin
            cnt_next = 6'h00;
            if (fault && !pulsed)
               state_next = OCP_HOLD;
            else if (fault)
               state_next = OCP_PULSE;
         end
         OCP_PULSE:
         begin
            if (tick)
               cnt_next = cnt_inc;
            if (pulse_done)
               state_next = OCP_WAIT;
         end
         OCP_WAIT:
         begin
            if (tick)
               cnt_next = cnt_inc;
            if (REPEAT_EN && fault && repeat_done)
            begin
               state_next = OCP_PULSE;
               cnt_next = 6'h00;
            end
            else if (!fault && (!REPEAT_EN || repeat_done))
               state_next = OCP_IDLE;
            else if (!REPEAT_EN && !fault)
               state_next = OCP_IDLE;
         end
         OCP_HOLD:
         begin
            if (!fault && unit_reset)
               state_next = OCP_IDLE;
         end
      endcase
   end

   // state registers; coil from a flip-flop
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= OCP_IDLE;
         cnt_reg <= 6'h00;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         coil <= 1'b0;
      else
         coil <= (state_next == OCP_PULSE) || (state_next == OCP_HOLD);
   end

   assign busy = (state_reg != OCP_IDLE);

   // pulse does not end before the setting in ticks is reached
   AST_PULSE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      (state_reg == OCP_PULSE && !pulse_done) |=> state_reg == OCP_PULSE)
      else $error("pulse ended early");
   AST_LATCH_STAYS: assert property (@(posedge core_clk) disable iff (rst)
      (state_reg == OCP_HOLD && fault) |=> state_reg == OCP_HOLD)
      else $error("latched output dropped under fault");
   AST_LATCH_RELEASE: assert property (@(posedge core_clk) disable iff (rst)
      (state_reg == OCP_HOLD && !fault && unit_reset) |=> !coil)
      else $error("latched output not released");
   AST_REPEAT: assert property (@(posedge core_clk) disable iff (rst)
      (REPEAT_EN && state_reg == OCP_WAIT && fault && repeat_done) |=> ##[0:1] coil)
      else $error("trip pulse did not repeat");
   AST_NO_REPEAT_SPARE: assert property (@(posedge core_clk) disable iff (rst)
      (!REPEAT_EN && state_reg == OCP_WAIT) |=> state_reg != OCP_PULSE)
      else $error("spare output repeated");
endmodule : ocp_channel

// [sim/ocp_far_side.sv]
// far side model: protection fault sources and the contact coils
`timescale 1ns/100ps
module ocp_far_side
   import ocp_pkg::*;
(
   // clock
   input wire logic core_clk,
   // fault requests and unit reset toward the block
   output logic [OCP_NUM_OUT-1:0] fault_req,
   output logic ext_unit_reset,
   // coil drive from the block
   input wire logic [OCP_NUM_OUT-1:0] coil_drive
);
   logic [OCP_NUM_OUT-1:0] coil_q = '0;
   int rise_cnt [OCP_NUM_OUT] = '{default: 0};

   initial
   begin
      fault_req = '0;
      ext_unit_reset = 1'b0;
   end

   // count coil pick-ups; a coil that chatters shows up as extra rises
   always @(posedge core_clk)
   begin
      for (int i = 0; i < OCP_NUM_OUT; i++)
         if (coil_drive[i] === 1'b1 && coil_q[i] !== 1'b1)
            rise_cnt[i]++;
      coil_q <= coil_drive;
   end

   // fault levels change just after an edge, as a real relay input would
   task automatic set_fault(input logic [OCP_NUM_OUT-1:0] mask);
      @(posedge core_clk);
      fault_req <= mask;
   endtask : set_fault

   // one-cycle external reset request
   task automatic pulse_reset();
      @(posedge core_clk);
      ext_unit_reset <= 1'b1;
      @(posedge core_clk);
      ext_unit_reset <= 1'b0;
   endtask : pulse_reset
endmodule : ocp_far_side

// [sim/ocp_top_tb_top.sv]
// self-checking bench for the output contact pulse latch
`timescale 1ns/100ps
module ocp_top_tb_top
   import ocp_pkg::*;
();
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   // short tick so pulse widths and the 3 s repeat fit in the run
   localparam int TB_TICK = 20;
   // long enough for three trip pulses, short of a fourth
   localparam int PULSE_WINDOW = 1300;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [OCP_NUM_OUT-1:0] fault_req;
   logic ext_unit_reset;
   logic [OCP_NUM_OUT-1:0] coil_drive;
   logic [31:0] rd_word;
   int n_errors = 0;
   int check_count = 0;

   always #5 core_clk = ~core_clk;

   ocp_top #(.TICK_CYCLES(TB_TICK)) DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .fault_req(fault_req), .ext_unit_reset(ext_unit_reset),
      .coil_drive(coil_drive));
   ocp_far_side far (.core_clk(core_clk), .fault_req(fault_req), .ext_unit_reset(ext_unit_reset),
      .coil_drive(coil_drive));

   // ------------------------------------------------------------
   // reporting and comparison
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run

   task automatic note_fail(input string what);
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, what);
   endtask : note_fail

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
         note_fail($sformatf("word got %h expected %h", got, exp));
   endtask : cmp_word

   // coils may take a few edges to follow a request, so allow a short bounded wait
   task automatic cmp_coil(input logic [OCP_NUM_OUT-1:0] exp);
      check_count++;
      for (int i = 0; i < 20 && coil_drive !== exp; i++)
         @(posedge core_clk);
      if (coil_drive !== exp)
         note_fail($sformatf("coils %h expected %h", coil_drive, exp));
   endtask : cmp_coil

   // a cycle count that may land anywhere inside one tick of slack
   task automatic cmp_span(input int got, input int lo, input int hi_lim);
      check_count++;
      if (got < lo || got > hi_lim)
         note_fail($sformatf("count %0d outside %0d..%0d", got, lo, hi_lim));
   endtask : cmp_span

   // ------------------------------------------------------------
   // avalon master: hold until waitrequest is seen low at an edge
   // ------------------------------------------------------------
   task automatic bus_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] data);
      int i;
      @(posedge core_clk);
      avs_address <= addr;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= data;
      for (i = 0; i < 50; i++)
      begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      if (i == 50)
      begin
         note_fail("bus answer never came");
         complete_run();
      end
      rd_word = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus_xfer

   task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
      bus_xfer(1'b0, addr, 32'h0);
      cmp_word(rd_word, exp);
   endtask : rd_chk

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic scn_reset_values();
      rd_chk(OCP_ADDR_MODE, 32'h0);
      for (int a = 1; a <= 4; a++)
         rd_chk(4'(a), {27'h0, OCP_TIME_DEFAULT});
      rd_chk(OCP_ADDR_STATUS, 32'h0);
      rd_chk(4'h7, 32'h0);
   endtask : scn_reset_values

   // boundaries of each pulse time; out-of-range writes must leave the value alone
   task automatic scn_time_range();
      for (int a = 1; a <= 4; a++)
      begin
         bus_xfer(1'b1, 4'(a), {27'h0, OCP_TIME_MAX});
         rd_chk(4'(a), {27'h0, OCP_TIME_MAX});
         bus_xfer(1'b1, 4'(a), {27'h0, OCP_TIME_MAX} + 32'h1);
         rd_chk(4'(a), {27'h0, OCP_TIME_MAX});
         bus_xfer(1'b1, 4'(a), 32'h0);
         rd_chk(4'(a), {27'h0, OCP_TIME_MAX});
         bus_xfer(1'b1, 4'(a), {27'h0, OCP_TIME_MIN});
         rd_chk(4'(a), {27'h0, OCP_TIME_MIN});
      end
      bus_xfer(1'b1, 4'h9, 32'hffff_ffff);
      rd_chk(4'h9, 32'h0);
      bus_xfer(1'b1, OCP_ADDR_STATUS, 32'hff);
      rd_chk(OCP_ADDR_STATUS, 32'h0);
   endtask : scn_time_range

   // the mode register takes a mixed per-output setting and reads it back
   task automatic scn_modes();
      bus_xfer(1'b1, OCP_ADDR_MODE, 32'h35);
      rd_chk(OCP_ADDR_MODE, 32'h35);
      bus_xfer(1'b1, OCP_ADDR_MODE, 32'h0);
   endtask : scn_modes

   // latched: a reset while the fault stands must not drop the coils
   task automatic scn_latched();
      far.set_fault(4'hf);
      cmp_coil(4'hf);
      rd_chk(OCP_ADDR_STATUS, 32'hff);
      cmp_word(rd_word & 32'hf, 32'hf);
      bus_xfer(1'b1, OCP_ADDR_RESET, 32'h1);
      repeat (10) @(posedge core_clk);
      cmp_coil(4'hf);
      far.set_fault(4'h0);
      repeat (30) @(posedge core_clk);
      cmp_coil(4'hf);
      bus_xfer(1'b1, OCP_ADDR_RESET, 32'h1);
      cmp_coil(4'h0);
      far.set_fault(4'h4);
      cmp_coil(4'h4);
      far.set_fault(4'h0);
      repeat (30) @(posedge core_clk);
      cmp_coil(4'h4);
      far.pulse_reset();
      cmp_coil(4'h0);
   endtask : scn_latched

   // pulsed: widths in whole ticks (first tick partial), trip repeats, spares once
   task automatic scn_pulsed();
      int hi [OCP_NUM_OUT];
      int base [OCP_NUM_OUT];
      bus_xfer(1'b1, OCP_ADDR_TRIP_TIME, 32'h3);
      bus_xfer(1'b1, OCP_ADDR_SPARE1_TIME, 32'h2);
      bus_xfer(1'b1, OCP_ADDR_SPARE2_TIME, 32'h2);
      bus_xfer(1'b1, OCP_ADDR_SPARE3_TIME, 32'h2);
      bus_xfer(1'b1, OCP_ADDR_MODE, 32'hf);
      for (int i = 0; i < OCP_NUM_OUT; i++)
      begin
         hi[i] = 0;
         base[i] = far.rise_cnt[i];
      end
      far.set_fault(4'hf);
      repeat (PULSE_WINDOW)
      begin
         @(posedge core_clk);
         for (int i = 0; i < OCP_NUM_OUT; i++)
            hi[i] += (coil_drive[i] === 1'b1) ? 1 : 0;
      end
      // one partial plus two full trip pulses of three ticks
      cmp_span(hi[0], 8 * TB_TICK + 1, 9 * TB_TICK);
      cmp_word(32'(far.rise_cnt[0] - base[0]), 32'h3);
      for (int i = 1; i < OCP_NUM_OUT; i++)
      begin
         cmp_span(hi[i], TB_TICK + 1, 2 * TB_TICK);
         cmp_word(32'(far.rise_cnt[i] - base[i]), 32'h1);
      end
      far.set_fault(4'h0);
      cmp_coil(4'h0);
      // blocking, lockout and out of service force the spares latched
      bus_xfer(1'b1, OCP_ADDR_MODE, 32'h7f);
      far.set_fault(4'he);
      repeat (3 * TB_TICK) @(posedge core_clk);
      cmp_coil(4'he);
      far.set_fault(4'h0);
      far.pulse_reset();
      cmp_coil(4'h0);
      bus_xfer(1'b1, OCP_ADDR_MODE, 32'h0);
   endtask : scn_pulsed

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      avs_address <= 4'h0;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= 32'h0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      scn_reset_values();
      scn_time_range();
      scn_modes();
      scn_latched();
      scn_pulsed();
      complete_run();
   end
endmodule : ocp_top_tb_top
